//--- cca_cfg.svh
// Constants of the camera-side control channel: codes, layout, timing.
// Included by the package and the design; holds definitions only.
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH
`define CCA_TYPE_CMD    8'h02
`define CCA_TYPE_ACK    8'h03
`define CCA_OP_READ     8'h00
`define CCA_OP_WRITE    8'h01
`define CCA_OP_RESET    8'hFF
`define CCA_ACK_READ    8'h00
`define CCA_ACK_WRITE   8'h01
`define CCA_ACK_RESET   8'h03
`define CCA_ACK_WAIT    8'h04
`define CCA_ERR_ADDR    8'h40
`define CCA_ERR_OPCODE  8'h42
`define CCA_ERR_RDONLY  8'h43
`define CCA_ERR_BIG     8'h45
`define CCA_ERR_SIZE    8'h46
`define CCA_ERR_MALF    8'h47
`define CCA_ERR_CRC     8'h80
`define CCA_DEPTH       64
`define CCA_IDX_W       7
`define CCA_HDR_WORDS   7'h03
`define CCA_PKT_OVH     27'h0000018
`define CCA_BOOT_END    32'h00004000
`define CCA_CLK_KHZ     40000
`define CCA_ACK_MS      200
`define CCA_WAITSEND_MS 100
`define CCA_WAIT_MIN_MS 32'h00000064
`define CCA_WAIT_MAX_MS 32'h00002710
`define CCA_TMR_W       24
`endif

//--- cca_pkg.sv
// Types of the camera-side control channel.
// Assumes cca_cfg.svh sits in the same folder.
`include "cca_cfg.svh"
package cca_pkg;
  typedef enum logic [2:0] {
    CCA_IDLE  = 3'h0,
    CCA_RX    = 3'h1,
    CCA_CHK   = 3'h3,
    CCA_EXEC  = 3'h2,
    CCA_ACODE = 3'h6,
    CCA_ASIZE = 3'h7,
    CCA_ADATA = 3'h5,
    CCA_ACRC  = 3'h4
  } cca_state_t;

  typedef struct packed {
    logic        valid;
    logic        sop;
    logic        last;
    logic [7:0]  ptype;
    logic [31:0] data;
    logic        crc_bad;
  } cca_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic        crc_slot;
    logic [7:0]  ptype;
    logic [31:0] data;
  } cca_ack_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } cca_mreq_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [7:0]  err_code;
    logic [31:0] rdata;
    logic        speed_chg;
  } cca_mrsp_t;
endpackage : cca_pkg

//--- cca_ctrl_channel.sv
// Camera-side control channel: parses command payloads, runs register
// accesses, builds acknowledgment payloads. Framing and CRC math sit
// outside; the framer fills the word flagged crc_slot.
//
// Overview of operation
// - Acknowledgments go out only in answer to a received command.
// - Master connection reads and writes; extension connection only reads.
// - Valid command executes first; final acknowledgment follows completion.
// - Invalid command is dropped and its error acknowledged at once.
// - Execution plus final acknowledgment fits in 200ms unless waiting.
// - One wait acknowledgment within 200ms; never for bootstrap addresses.
// - Channel reset aborts work, resets only this block, acks 0x03.
// - Speed change applies only after its write acknowledgment is sent; code also applies it after an error acknowledgment of that command.
// - Commands are type 0x02; opcode read, write, reset, else reserved.
// - 24-bit byte count; at least one for access, zero for reset.
// - Word 1 is start address, ascending; zero for reset.
// - Data fields are ceil(B/4) words, trailing bytes zero.
// - Commands and data acknowledgments end with a CRC word.
// - Acknowledgments are type 0x03, code repeated in all characters.
// - Success codes: 0x00 read data, 0x01 write, 0x03 reset.
// - Wait code 0x04 carries milliseconds, 100ms to 10s.
// - Logical errors 0x40 to 0x47; 0x80 for CRC failure.
// - Codes other than 0x00 and 0x04 end after the code word.
// - Read reply byte count equals the command byte count.
// - Whole control packet stays within the discovered size limit.
`timescale 1ns/1ps
`include "cca_cfg.svh"
module cca_ctrl_channel
  import cca_pkg::*;
#(
  parameter int unsigned WAIT_SEND_CYC = `CCA_WAITSEND_MS * `CCA_CLK_KHZ,
  parameter int unsigned ACK_LIMIT_CYC = `CCA_ACK_MS * `CCA_CLK_KHZ
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire cca_cmd_t    cmd_i,
  output cca_ack_t         ack_o,
  input  wire logic        ack_ready,
  output cca_mreq_t        mem_o,
  input  wire cca_mrsp_t   mem_i,
  input  wire logic        is_master,
  input  wire logic [31:0] max_control_packet_bytes,
  input  wire logic [31:0] wait_ms,
  output logic             link_speed_apply
);
  localparam int unsigned D = `CCA_DEPTH;

  typedef struct packed {
    cca_state_t                 st;
    logic [7:0]                 op;
    logic [23:0]                size;
    logic [31:0]                addr;
    logic [`CCA_IDX_W-1:0]      cnt;
    logic [`CCA_IDX_W-1:0]      idx;
    logic                       crc_bad;
    logic [D-1:0][31:0]         buf_w;
    logic [7:0]                 code;
    logic                       busy;
    logic                       waited;
    logic                       wsend;
    logic                       spd;
    logic                       apply;
    logic [`CCA_TMR_W-1:0]      tmr;
  } cca_regs_t;

  cca_regs_t r_ff, nxt_r;

  // Byte lanes holding real data in word w of a B-byte field
  function automatic logic [3:0] lanes(input logic [23:0] b,
                                       input logic [`CCA_IDX_W-1:0] w);
    logic [24:0] rem;
    rem = {1'b0, b} - {16'h0000, w, 2'b00};
    if (rem >= 25'h0000004) lanes = 4'hF;
    else lanes = 4'hF >> (3'h4 - rem[2:0]);
  endfunction : lanes

  function automatic logic [31:0] expand(input logic [3:0] be);
    expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : expand

  // ----------------------------------------------------------------
  // Derived sizes
  // ----------------------------------------------------------------
  logic [22:0] nw;
  logic [26:0] pkt_bytes;
  logic [22:0] ack_n;
  logic        boot_addr;
  logic        rst_cmd;
  logic        ack_has_data;

  assign nw = 23'((25'(r_ff.size) + 25'h3) >> 2);
  assign pkt_bytes = {2'b00, nw, 2'b00} + `CCA_PKT_OVH;
  assign ack_n = r_ff.wsend ? 23'h1 : nw;
  assign boot_addr = r_ff.addr < `CCA_BOOT_END;
  assign rst_cmd = cmd_i.valid && cmd_i.sop && cmd_i.ptype == `CCA_TYPE_CMD
                   && cmd_i.data[7:0] == `CCA_OP_RESET;
  assign ack_has_data = r_ff.code == `CCA_ACK_READ
                        || r_ff.code == `CCA_ACK_WAIT;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.apply = 1'b0;
    if (r_ff.st != CCA_IDLE && r_ff.st != CCA_RX)
      nxt_r.tmr = r_ff.tmr + 1'b1;
    if (r_ff.busy && mem_i.done) begin
      nxt_r.busy = 1'b0;
      nxt_r.idx = r_ff.idx + 1'b1;
      if (mem_i.err) nxt_r.code = mem_i.err_code;
      if (mem_i.speed_chg) nxt_r.spd = 1'b1;
      if (r_ff.op == `CCA_OP_READ)
        nxt_r.buf_w[r_ff.idx[5:0]] = mem_i.rdata
          & expand(lanes(r_ff.size, r_ff.idx));
    end
    if (r_ff.st != CCA_IDLE && r_ff.st != CCA_RX && rst_cmd) begin
      nxt_r = '0;
      nxt_r.st = CCA_RX;
      nxt_r.op = cmd_i.data[7:0];
      nxt_r.size = cmd_i.data[31:8];
      nxt_r.cnt = 7'h01;
      nxt_r.crc_bad = cmd_i.crc_bad;
      if (cmd_i.last) nxt_r.st = CCA_CHK;
    end else begin
      case (r_ff.st)
        CCA_IDLE, CCA_RX: begin
          if (cmd_i.valid && cmd_i.ptype == `CCA_TYPE_CMD
              && (cmd_i.sop || r_ff.st == CCA_RX)) begin
            if (cmd_i.sop) begin
              nxt_r.op = cmd_i.data[7:0];
              nxt_r.size = cmd_i.data[31:8];
              nxt_r.cnt = 7'h01;
              nxt_r.crc_bad = 1'b0;
            end else begin
              if (r_ff.cnt == 7'h01) nxt_r.addr = cmd_i.data;
              else if (r_ff.cnt - 7'h02 < 7'(D))
                nxt_r.buf_w[6'(r_ff.cnt - 7'h02)] = cmd_i.data;
              if (r_ff.cnt != 7'h7F) nxt_r.cnt = r_ff.cnt + 1'b1;
            end
            nxt_r.crc_bad = cmd_i.crc_bad;
            nxt_r.st = cmd_i.last ? CCA_CHK : CCA_RX;
          end
        end
        CCA_CHK: begin
          nxt_r.tmr = '0;
          nxt_r.idx = '0;
          nxt_r.waited = 1'b0;
          nxt_r.wsend = 1'b0;
          nxt_r.spd = 1'b0;
          nxt_r.st = CCA_ACODE;
          if (r_ff.crc_bad) nxt_r.code = `CCA_ERR_CRC;
          else if (r_ff.op != `CCA_OP_READ && r_ff.op != `CCA_OP_WRITE
                   && r_ff.op != `CCA_OP_RESET)
            nxt_r.code = `CCA_ERR_OPCODE;
          // Word count covers word 0, the address and the CRC word
          else if (r_ff.cnt < `CCA_HDR_WORDS)
            nxt_r.code = `CCA_ERR_MALF;
          else if (r_ff.op == `CCA_OP_RESET)
            nxt_r.code = (r_ff.size == '0 && r_ff.addr == '0
                          && r_ff.cnt == `CCA_HDR_WORDS)
                         ? `CCA_ACK_RESET : `CCA_ERR_MALF;
          else if (r_ff.size == '0) nxt_r.code = `CCA_ERR_MALF;
          else if (nw > 23'(D)
                   || 32'(pkt_bytes) > max_control_packet_bytes)
            nxt_r.code = `CCA_ERR_BIG;
          else if (r_ff.cnt != ((r_ff.op == `CCA_OP_WRITE)
                   ? 7'(nw) + `CCA_HDR_WORDS
                   : `CCA_HDR_WORDS))
            nxt_r.code = `CCA_ERR_SIZE;
          else if (r_ff.op == `CCA_OP_WRITE && !is_master)
            nxt_r.code = `CCA_ERR_RDONLY;
          else begin
            nxt_r.code = (r_ff.op == `CCA_OP_WRITE) ? `CCA_ACK_WRITE
                                                    : `CCA_ACK_READ;
            nxt_r.st = CCA_EXEC;
          end
        end
        CCA_EXEC: begin
          if (!r_ff.busy) begin
            if (r_ff.tmr >= `CCA_TMR_W'(WAIT_SEND_CYC) && !r_ff.waited
                && !boot_addr) begin
              nxt_r.waited = 1'b1;
              nxt_r.wsend = 1'b1;
              nxt_r.st = CCA_ACODE;
            end else if (r_ff.code != `CCA_ACK_READ
                         && r_ff.code != `CCA_ACK_WRITE)
              nxt_r.st = CCA_ACODE;
            else if (23'(r_ff.idx) == nw) nxt_r.st = CCA_ACODE;
            else nxt_r.busy = 1'b1;
          end
        end
        CCA_ACODE: begin
          if (ack_ready) begin
            nxt_r.cnt = '0;
            if (r_ff.wsend || ack_has_data) nxt_r.st = CCA_ASIZE;
            else nxt_r.st = CCA_IDLE;
            if (!r_ff.wsend && !ack_has_data) nxt_r.apply = r_ff.spd;
          end
        end
        CCA_ASIZE:
          if (ack_ready) nxt_r.st = CCA_ADATA;
        CCA_ADATA:
          if (ack_ready) begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
            if (23'(r_ff.cnt) + 23'h1 == ack_n) nxt_r.st = CCA_ACRC;
          end
        CCA_ACRC:
          if (ack_ready) begin
            nxt_r.st = r_ff.wsend ? CCA_EXEC : CCA_IDLE;
            nxt_r.wsend = 1'b0;
          end
        default: nxt_r.st = CCA_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) r_ff <= '0;
    else r_ff <= nxt_r;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [31:0] wait_val;
  assign wait_val = (wait_ms < `CCA_WAIT_MIN_MS) ? `CCA_WAIT_MIN_MS
                  : (wait_ms > `CCA_WAIT_MAX_MS) ? `CCA_WAIT_MAX_MS
                  : wait_ms;

  always_comb begin
    ack_o = '0;
    ack_o.ptype = `CCA_TYPE_ACK;
    ack_o.valid = r_ff.st == CCA_ACODE || r_ff.st == CCA_ASIZE
                  || r_ff.st == CCA_ADATA || r_ff.st == CCA_ACRC;
    case (r_ff.st)
      CCA_ACODE: begin
        ack_o.data = r_ff.wsend ? {4{`CCA_ACK_WAIT}} : {4{r_ff.code}};
        ack_o.last = !r_ff.wsend && !ack_has_data;
      end
      CCA_ASIZE:
        ack_o.data = r_ff.wsend ? 32'h00000004 : {8'h00, r_ff.size};
      CCA_ADATA:
        ack_o.data = r_ff.wsend ? wait_val : r_ff.buf_w[r_ff.cnt[5:0]];
      CCA_ACRC: begin
        ack_o.crc_slot = 1'b1;
        ack_o.last = 1'b1;
      end
      default: ack_o.data = '0;
    endcase
    mem_o.valid = r_ff.busy;
    mem_o.we = r_ff.op == `CCA_OP_WRITE;
    mem_o.addr = r_ff.addr + {23'h000000, r_ff.idx, 2'b00};
    mem_o.be = lanes(r_ff.size, r_ff.idx);
    mem_o.wdata = r_ff.buf_w[r_ff.idx[5:0]];
  end

  assign link_speed_apply = r_ff.apply;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic ack_end;
  assign ack_end = ack_o.valid && ack_o.last && ack_ready;

  no_ext_write_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) mem_o.valid && mem_o.we |-> is_master)
    else $error("write issued on extension connection");
  exec_before_ack_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) ack_o.valid |-> !mem_o.valid || r_ff.wsend)
    else $error("final acknowledgment while access pending");
  err_ack_fast_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    r_ff.st == CCA_CHK && nxt_r.code[7:6] != 2'b00 |=> ack_o.valid)
    else $error("error acknowledgment not immediate");
  ack_in_time_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    ack_o.valid && !r_ff.waited |-> r_ff.tmr < `CCA_TMR_W'(ACK_LIMIT_CYC))
    else $error("acknowledgment later than its limit");
  boot_no_wait_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) r_ff.wsend |-> !boot_addr && r_ff.waited)
    else $error("wait acknowledgment for bootstrap access");
  wait_once_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) r_ff.waited && !r_ff.wsend |=> !r_ff.wsend)
    else $error("second wait acknowledgment");
  reset_abort_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) rst_cmd && r_ff.st == CCA_EXEC |=> !mem_o.valid)
    else $error("reset did not abort access");
  // Well-formed reset packet: word 0, address word, CRC word
  reset_ack_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    r_ff.st == CCA_CHK && !rst_cmd && !r_ff.crc_bad
      && r_ff.op == `CCA_OP_RESET && r_ff.size == '0 && r_ff.addr == '0
      && r_ff.cnt == `CCA_HDR_WORDS
      |=> ack_o.valid && ack_o.last && ack_o.data == {4{`CCA_ACK_RESET}})
    else $error("channel reset not acknowledged");
  speed_after_ack_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) link_speed_apply |-> $past(ack_end))
    else $error("speed applied before acknowledgment");
  short_ack_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    r_ff.st == CCA_ACODE && !r_ff.wsend && !ack_has_data |-> ack_o.last)
    else $error("short acknowledgment not ended");
  wait_range_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    r_ff.st == CCA_ADATA && r_ff.wsend |-> ack_o.data >= `CCA_WAIT_MIN_MS
      && ack_o.data <= `CCA_WAIT_MAX_MS)
    else $error("wait time out of range");
endmodule : cca_ctrl_channel

//--- cca_host_model.sv
// Host stand-in: sends command payloads, collects ack payload words.
// Assumes cca_pkg is compiled first; ack words arrive as cca_ack_t.
`timescale 1ns/1ps
`include "cca_cfg.svh"
module cca_host_model
  import cca_pkg::*;
(
  input  wire logic     ref_clk,
  output cca_cmd_t      cmd_o,
  input  wire cca_ack_t ack_i,
  output logic          ack_ready
);
  // ------------------------------------------------
  // Sender and collector
  // ------------------------------------------------
  logic [31:0] aq[$];
  int          npk = 0;

  initial cmd_o = '0;
  initial ack_ready = 1'h0;

  // Bench calls this only after the final ack, or for a reset
  task automatic send(input logic [31:0] w[$], input logic bad);
    foreach (w[i]) begin
      @(negedge ref_clk);
      cmd_o = {1'b1, 1'(i == 0), 1'(i == w.size() - 1),
               `CCA_TYPE_CMD, w[i], 1'(bad && (i == w.size() - 1))};
    end
    @(negedge ref_clk);
    // Idle bus must not show a stale word
    cmd_o = {3'b000, 8'h00, ~w[w.size() - 1], 1'b0};
  endtask : send

  // Stalls about a quarter of the time
  always @(negedge ref_clk)
    ack_ready <= ($urandom_range(3) != 0);

  // Framer stand-in puts a marker where the CRC goes
  always @(posedge ref_clk)
    if (ack_i.valid && ack_ready) begin
      aq.push_back(ack_i.crc_slot ? 32'hCCCCCCCC : ack_i.data);
      if (ack_i.last)
        npk++;
    end
endmodule : cca_host_model

//--- control_channel_cmd_ack_tb.sv
// Bench of the control channel: host stand-in, register space with
// adjustable latency, reference contents kept in an associative array.
// Assumes cca_pkg and cca_host_model are compiled first.
`timescale 1ns/1ps
`include "cca_cfg.svh"
module control_channel_cmd_ack_tb;
  import cca_pkg::*;
  // ------------------------------------------------
  // Clock, design, partner
  // ------------------------------------------------
  logic        ref_clk = 1'h0;
  logic        resetn = 1'h0;
  cca_cmd_t    cmd;
  cca_ack_t    ack;
  logic        ack_ready;
  cca_mreq_t   mem_o;
  cca_mrsp_t   mem_i = '0;
  logic        is_master = 1'h1;
  logic [31:0] max_bytes = 32'h00000400;
  logic [31:0] wait_ms = 32'h00000005;
  logic        apply;
  logic        mhang = 1'h0;
  logic        mspd = 1'h0;
  logic        lacc = 1'h0;
  logic [7:0]  merr = 8'h00;
  logic [7:0]  op;
  logic [7:0]  ec[3] = '{8'h40, 8'h41, 8'h44};
  logic [31:0] mem[logic [31:0]];
  logic [31:0] rm[logic [31:0]];
  int          n_fail = 0;
  int          samples_checked = 0;
  int          mdly = 0;
  int          mcnt = 0;
  int          napply = 0;
  int          p;
  int          b;

  always #12.5 ref_clk = ~ref_clk;

  cca_ctrl_channel #(.WAIT_SEND_CYC(50), .ACK_LIMIT_CYC(100))
    i_cca_ctrl_channel (.ref_clk(ref_clk), .resetn(resetn), .cmd_i(cmd),
    .ack_o(ack), .ack_ready(ack_ready), .mem_o(mem_o), .mem_i(mem_i),
    .is_master(is_master), .max_control_packet_bytes(max_bytes),
    .wait_ms(wait_ms), .link_speed_apply(apply));
  cca_host_model i_cca_host_model (.ref_clk(ref_clk), .cmd_o(cmd),
    .ack_i(ack), .ack_ready(ack_ready));

  // Register space; mhang holds an access open forever
  always @(negedge ref_clk) begin
    mem_i <= '0;
    if (!mem_o.valid || mem_i.done)
      mcnt = 0;
    else if (!mhang && mcnt++ >= mdly) begin
      mem_i.done <= 1'h1;
      mem_i.err <= (merr != 8'h00);
      mem_i.err_code <= merr;
      mem_i.speed_chg <= mspd;
      mem_i.rdata <= mem.exists(mem_o.addr) ? mem[mem_o.addr] : ~mem_o.addr;
      if (mem_o.we && merr == 8'h00)
        mem[mem_o.addr] = mem_o.wdata & {{8{mem_o.be[3]}}, {8{mem_o.be[2]}},
                                         {8{mem_o.be[1]}}, {8{mem_o.be[0]}}};
    end
  end

  always @(posedge ref_clk) begin
    if (ack.valid)
      chk({24'h0, ack.ptype}, {24'h0, `CCA_TYPE_ACK});
    if (apply) begin
      chk({31'h0, lacc}, 32'h1);
      napply++;
    end
    lacc <= ack.valid && ack_ready && ack.last;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] msk(input int b, input int i);
    if (i == (b - 1) / 4 && b % 4 != 0)
      return ~(32'hFFFFFFFF << (8 * (b % 4)));
    return 32'hFFFFFFFF;
  endfunction : msk

  // ex 8'hFF: success expected; wt: one wait ack comes first
  task automatic xact(input logic [7:0] op, input int b,
                      input logic [31:0] a, input int nd, input logic bad,
                      input logic [7:0] ex, input logic wt);
    logic [31:0] w[$];
    logic [31:0] e[$];
    logic [31:0] d;
    logic [7:0]  c;
    int          p;
    w = '{{b[23:0], op}, a};
    for (int i = 0; i < nd; i++) begin
      d = $urandom() & msk(b, i);
      w.push_back(d);
      if (ex == 8'hFF)
        rm[a + 4 * i] = d;
    end
    w.push_back(32'h0);
    if (wt)
      e = '{{4{`CCA_ACK_WAIT}}, 32'h4, 32'h64, 32'hCCCCCCCC};
    c = (ex != 8'hFF) ? ex : (op == `CCA_OP_READ) ? `CCA_ACK_READ :
        (op == `CCA_OP_WRITE) ? `CCA_ACK_WRITE : `CCA_ACK_RESET;
    e.push_back({4{c}});
    if (c == `CCA_ACK_READ) begin
      e.push_back(b);
      for (int i = 0; i < (b + 3) / 4; i++)
        e.push_back((rm.exists(a + 4 * i) ? rm[a + 4 * i] : ~(a + 4 * i))
                    & msk(b, i));
      e.push_back(32'hCCCCCCCC);
    end
    p = i_cca_host_model.npk + (wt ? 2 : 1);
    i_cca_host_model.send(w, bad);
    for (int t = 0; t < 400 && i_cca_host_model.npk < p; t++)
      @(negedge ref_clk);
    chk(i_cca_host_model.aq.size(), e.size());
    foreach (e[i])
      chk(i_cca_host_model.aq[i], e[i]);
    i_cca_host_model.aq.delete();
  endtask : xact

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial begin
    void'($urandom(64862));
    repeat (20) @(negedge ref_clk);
    resetn = 1'h1;
    repeat (4) @(negedge ref_clk);
    chk(i_cca_host_model.aq.size(), 0);
    xact(8'h01, 6, 32'h100, 2, 0, 8'hFF, 0);
    xact(8'h07, 4, 32'h100, 1, 0, 8'h42, 0);
    xact(8'h01, 4, 32'h100, 1, 1, 8'h80, 0);
    xact(8'h01, 8, 32'h100, 1, 0, 8'h46, 0);
    xact(8'h00, 0, 32'h100, 0, 0, 8'h47, 0);
    xact(8'hFF, 1, 32'h0, 0, 0, 8'h47, 0);
    xact(8'hFF, 0, 32'h0, 0, 0, 8'hFF, 0);
    is_master = 1'h0;
    xact(8'h01, 4, 32'h100, 1, 0, 8'h43, 0);
    xact(8'h00, 6, 32'h100, 0, 0, 8'hFF, 0);
    is_master = 1'h1;
    max_bytes = 32'h00000028;
    xact(8'h00, 20, 32'h100, 0, 0, 8'h45, 0);
    xact(8'h00, 16, 32'h100, 0, 0, 8'hFF, 0);
    max_bytes = 32'h00000400;
    foreach (ec[i]) begin
      merr = ec[i];
      xact(8'h00, 4, 32'h200, 0, 0, ec[i], 0);
    end
    merr = 8'h00;
    mspd = 1'h1;
    p = napply;
    xact(8'h01, 4, 32'h300, 1, 0, 8'hFF, 0);
    mspd = 1'h0;
    repeat (3) @(negedge ref_clk);
    chk(napply, p + 1);
    mdly = 20;
    xact(8'h01, 16, 32'h8000, 4, 0, 8'hFF, 1);
    xact(8'h01, 16, 32'h104, 4, 0, 8'hFF, 0);
    mhang = 1'h1;
    i_cca_host_model.send('{32'h00000400, 32'h100, 32'h0}, 1'h0);
    // Host waits out the scaled silence limit before a new command
    repeat (100) @(negedge ref_clk);
    xact(8'hFF, 0, 32'h0, 0, 0, 8'hFF, 0);
    chk(mem_o.valid, 0);
    mhang = 1'h0;
    repeat (8) begin
      b = $urandom_range(12, 1);
      op = $urandom_range(1);
      mdly = $urandom_range(3);
      xact(op, b, 32'h9000 + 4 * $urandom_range(7), op ? (b + 3) / 4 : 0,
           0, 8'hFF, 0);
    end
    conclude();
  end

  initial begin
    #(25 * 20000);
    n_fail++;
    conclude();
  end
endmodule : control_channel_cmd_ack_tb
